/* design/lss_pkg.sv */
// Package: register map, selector codes and timing constants for the LED source select block
package lss_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	// Registers sit two 32-bit words apart (index 0x018 and 0x01A): byte address is four times the index
	localparam logic [9:0]  LSS_SRC_CFG_IDX   = 10'h018;
	localparam logic [9:0]  LSS_BLINK_CFG_IDX = 10'h01A;
	localparam logic [11:0] LSS_SRC_CFG_OFF   = {LSS_SRC_CFG_IDX, 2'b00};
	localparam logic [11:0] LSS_BLINK_CFG_OFF = {LSS_BLINK_CFG_IDX, 2'b00};

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          LSS_SEL_W        = 4;
	localparam int          LSS_IND0_LSB     = 0;
	localparam int          LSS_IND1_LSB     = 4;
	localparam int          LSS_IND2_LSB     = 8;
	localparam int          LSS_GPIO_LSB     = 12;
	localparam logic [15:0] LSS_SRC_CFG_RST  = 16'h6150;
	localparam logic [1:0]  LSS_BLINK_RST    = 2'h0;

	// ************************************************************
	// Selector codes
	// ************************************************************
	localparam logic [3:0] LSS_SEL_LINK     = 4'h0;
	localparam logic [3:0] LSS_SEL_ACT      = 4'h1;
	localparam logic [3:0] LSS_SEL_TX_ACT   = 4'h2;
	localparam logic [3:0] LSS_SEL_RX_ACT   = 4'h3;
	localparam logic [3:0] LSS_SEL_GIG_COL  = 4'h5;
	localparam logic [3:0] LSS_SEL_LINK100  = 4'h6;
	localparam logic [3:0] LSS_SEL_LINK10   = 4'h7;
	localparam logic [3:0] LSS_SEL_LINK10_100 = 4'h8;
	localparam logic [3:0] LSS_SEL_LINK100_1G = 4'h9;
	localparam logic [3:0] LSS_SEL_FDX      = 4'hA;
	localparam logic [3:0] LSS_SEL_LINK_BLINK = 4'hB;
	localparam logic [3:0] LSS_SEL_ANY_ERR  = 4'hD;
	localparam logic [3:0] LSS_SEL_RX_ERR   = 4'hE;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam longint LSS_CLK_HZ       = 10000000;
	localparam longint LSS_HALF_20HZ_MS = 25;
	localparam longint LSS_HALF_10HZ_MS = 50;
	localparam longint LSS_HALF_5HZ_MS  = 100;
	localparam longint LSS_HALF_2HZ_MS  = 250;
	localparam int LSS_HALF_20HZ_CYC = int'(LSS_CLK_HZ * LSS_HALF_20HZ_MS / 1000);
	localparam int LSS_HALF_10HZ_CYC = int'(LSS_CLK_HZ * LSS_HALF_10HZ_MS / 1000);
	localparam int LSS_HALF_5HZ_CYC  = int'(LSS_CLK_HZ * LSS_HALF_5HZ_MS / 1000);
	localparam int LSS_HALF_2HZ_CYC  = int'(LSS_CLK_HZ * LSS_HALF_2HZ_MS / 1000);

	// Link speed encoding
	typedef enum logic [1:0] {
		LSS_SPD_10   = 2'h0,
		LSS_SPD_100  = 2'h1,
		LSS_SPD_1000 = 2'h2
	} lss_speed_t;

endpackage : lss_pkg

/* design/lss_blinker.sv */
// Blink square wave generator with selectable half period
`timescale 1ns/1ps
module lss_blinker #(
	parameter int HALF_20HZ = lss_pkg::LSS_HALF_20HZ_CYC,
	parameter int HALF_10HZ = lss_pkg::LSS_HALF_10HZ_CYC,
	parameter int HALF_5HZ  = lss_pkg::LSS_HALF_5HZ_CYC,
	parameter int HALF_2HZ  = lss_pkg::LSS_HALF_2HZ_CYC
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] rate,
	output logic            blink
);
	import lss_pkg::*;

	logic [23:0] cnt_r;
	logic [23:0] half_w;

	always_comb begin
		case (rate)
			2'h0:    half_w = 24'(HALF_20HZ);
			2'h1:    half_w = 24'(HALF_10HZ);
			2'h2:    half_w = 24'(HALF_5HZ);
			default: half_w = 24'(HALF_2HZ);
		endcase
	end

	// Divider toggles the wave every half period; rate change takes effect at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 24'h00_0000;
			blink <= 1'b0;
		end else if (cnt_r >= half_w - 24'h00_0001) begin
			cnt_r <= 24'h00_0000;
			blink <= ~blink;
		end else begin
			cnt_r <= cnt_r + 24'h00_0001;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	blink_period_a : assert property (@(posedge pclk) disable iff (!presetn)
		$changed(blink) |-> ##1 (!$changed(blink))[*1] ##0 (cnt_r == 24'h00_0001))
		else $error("blink toggled without counter restart");

endmodule : lss_blinker

/* design/lss_top.sv */
// LED source select: APB register file and per-pin indication multiplexer
`timescale 1ns/1ps
// Summary of operation
// - Four 4-bit selectors in one register: GPIO 15:12, pin2 11:8, pin1 7:4, pin0 3:0.
// - Code 0001 any activity, 0010 transmit activity, 0011 receive activity.
// - Code 0110 lights while a 100 Mbps link is up.
// - Code 0111 lights while a 10 Mbps link is up.
// - Code 1000 lights while link is up at 10 or 100 Mbps.
// - Code 1001 lights while link is up at 100 or 1000 Mbps.
// - On pins 0 to 2, code 0101 lights while a gigabit link is up.
// - Code 0000 link up, 1011 link with activity blink, 1010 full duplex.
// - Code 1101 on receive or transmit error, 1110 on receive error only.
// - Blink rate from 2-bit setting: 2, 5, 10 Hz, or 20 Hz by default.
module lss_top #(
	parameter int HALF_20HZ = lss_pkg::LSS_HALF_20HZ_CYC,
	parameter int HALF_10HZ = lss_pkg::LSS_HALF_10HZ_CYC,
	parameter int HALF_5HZ  = lss_pkg::LSS_HALF_5HZ_CYC,
	parameter int HALF_2HZ  = lss_pkg::LSS_HALF_2HZ_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              link_up,
	input  wire lss_pkg::lss_speed_t link_speed,
	input  wire logic              full_duplex,
	input  wire logic              tx_active,
	input  wire logic              rx_active,
	input  wire logic              collision,
	input  wire logic              tx_error,
	input  wire logic              rx_error,
	output logic                   indicator0_pin,
	output logic                   indicator1_pin,
	output logic                   indicator2_pin,
	output logic                   gpio_indicator_pin
);
	import lss_pkg::*;

	// ************************************************************
	// APB register file
	// ************************************************************
	logic [15:0] led_source_config_r;
	logic [1:0]  indicator_blink_rate_r;
	logic        wr_en;
	logic        hit_src;
	logic        hit_blink;

	assign pready    = 1'b1;
	assign hit_src   = (paddr == LSS_SRC_CFG_OFF);
	assign hit_blink = (paddr == LSS_BLINK_CFG_OFF);
	assign wr_en     = psel && penable && pwrite;
	// Unmapped addresses answer with an error rather than silently aliasing
	assign pslverr   = psel && penable && !(hit_src || hit_blink);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_source_config_r <= LSS_SRC_CFG_RST;
		end else if (wr_en && hit_src) begin
			if (pstrb[0]) begin
				led_source_config_r[7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				led_source_config_r[15:8] <= pwdata[15:8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicator_blink_rate_r <= LSS_BLINK_RST;
		end else if (wr_en && hit_blink && pstrb[0]) begin
			indicator_blink_rate_r <= pwdata[1:0];
		end
	end

	// Read data registered in the setup cycle so it is stable for the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (hit_src) begin
				prdata <= {16'h0000, led_source_config_r};
			end else if (hit_blink) begin
				prdata <= {30'h0000_0000, indicator_blink_rate_r};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ************************************************************
	// Indication sources
	// ************************************************************
	logic blink;
	logic lnk10;
	logic lnk100;
	logic lnk1g;
	logic [3:0] pin_lvl;

	lss_blinker #(
		.HALF_20HZ (HALF_20HZ),
		.HALF_10HZ (HALF_10HZ),
		.HALF_5HZ  (HALF_5HZ),
		.HALF_2HZ  (HALF_2HZ)
	) lss_blinker_inst (
		.pclk    (pclk),
		.presetn (presetn),
		.rate    (indicator_blink_rate_r),
		.blink   (blink)
	);

	assign lnk10  = link_up && (link_speed == LSS_SPD_10);
	assign lnk100 = link_up && (link_speed == LSS_SPD_100);
	assign lnk1g  = link_up && (link_speed == LSS_SPD_1000);

	// ************************************************************
	// Per-pin multiplexer
	// ************************************************************
	// Pin outputs are registered, adding one cycle of latency, invisible at LED rates
	for (genvar i = 0; i < 4; i++) begin : g_pin
		logic [3:0] sel;
		logic       ind;
		logic       drv_r;
		assign sel = led_source_config_r[i*LSS_SEL_W +: LSS_SEL_W];
		always_comb begin
			case (sel)
				LSS_SEL_LINK:       ind = link_up;
				LSS_SEL_ACT:        ind = tx_active || rx_active;
				LSS_SEL_TX_ACT:     ind = tx_active;
				LSS_SEL_RX_ACT:     ind = rx_active;
				LSS_SEL_GIG_COL:    ind = (i == 3) ? collision : lnk1g;
				LSS_SEL_LINK100:    ind = lnk100;
				LSS_SEL_LINK10:     ind = lnk10;
				LSS_SEL_LINK10_100: ind = lnk10 || lnk100;
				LSS_SEL_LINK100_1G: ind = lnk100 || lnk1g;
				LSS_SEL_FDX:        ind = link_up && full_duplex;
				// Blink dims the lit LED only while traffic flows
				LSS_SEL_LINK_BLINK: ind = link_up && !((tx_active || rx_active) && blink);
				LSS_SEL_ANY_ERR:    ind = rx_error || tx_error;
				LSS_SEL_RX_ERR:     ind = rx_error;
				default:            ind = 1'b0;
			endcase
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				drv_r <= 1'b0;
			end else begin
				drv_r <= ind;
			end
		end
		// Each pin has its own flop so no vector is written from several processes
		assign pin_lvl[i] = drv_r;
	end

	assign indicator0_pin     = pin_lvl[0];
	assign indicator1_pin     = pin_lvl[1];
	assign indicator2_pin     = pin_lvl[2];
	assign gpio_indicator_pin = pin_lvl[3];

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cfg_write_a : assert property (wr_en && hit_src && pstrb == 4'hF
		|=> led_source_config_r == $past(pwdata[15:0]))
		else $error("source config not written");
	blink_write_a : assert property (wr_en && hit_blink && pstrb[0]
		|=> indicator_blink_rate_r == $past(pwdata[1:0]))
		else $error("blink rate not written");
	read_back_a : assert property (psel && !penable && !pwrite && hit_src
		|=> prdata == {16'h0000, $past(led_source_config_r)})
		else $error("source config read back wrong");
	reserved_off_a : assert property ((led_source_config_r[3:0] inside {4'h4, 4'hC, 4'hF})
		&& $stable(led_source_config_r) |=> !indicator0_pin)
		else $error("reserved code lit pin 0");
	gpio_coll_a : assert property (led_source_config_r[15:12] == LSS_SEL_GIG_COL
		&& $stable(led_source_config_r) |=> gpio_indicator_pin == $past(collision))
		else $error("gpio code 0101 not collision");
	gig_link_a : assert property (led_source_config_r[7:4] == LSS_SEL_GIG_COL
		&& $stable(led_source_config_r) |=> indicator1_pin == $past(lnk1g))
		else $error("pin 1 not gigabit link");
	link_any_a : assert property (led_source_config_r[11:8] == LSS_SEL_LINK
		&& $stable(led_source_config_r) |=> indicator2_pin == $past(link_up))
		else $error("pin 2 not link");
	act_or_a : assert property (led_source_config_r[11:8] == LSS_SEL_ACT
		&& $stable(led_source_config_r) |=> indicator2_pin == $past(tx_active || rx_active))
		else $error("pin 2 not activity");
	spd_100_a : assert property (led_source_config_r[15:12] == LSS_SEL_LINK100
		&& $stable(led_source_config_r) |=> gpio_indicator_pin == $past(lnk100))
		else $error("gpio pin not 100 Mbps link");
	spd_10_a : assert property (led_source_config_r[7:4] == LSS_SEL_LINK10
		&& $stable(led_source_config_r) |=> indicator1_pin == $past(lnk10))
		else $error("pin 1 not 10 Mbps link");
	spd_10_100_a : assert property (led_source_config_r[3:0] == LSS_SEL_LINK10_100
		&& $stable(led_source_config_r) |=> indicator0_pin == $past(lnk10 || lnk100))
		else $error("pin 0 not 10/100 link");
	spd_100_1g_a : assert property (led_source_config_r[11:8] == LSS_SEL_LINK100_1G
		&& $stable(led_source_config_r) |=> indicator2_pin == $past(lnk100 || lnk1g))
		else $error("pin 2 not 100/1000 link");
	link_blink_a : assert property (led_source_config_r[3:0] == LSS_SEL_LINK_BLINK
		&& $stable(led_source_config_r) && !tx_active && !rx_active
		|=> indicator0_pin == $past(link_up))
		else $error("pin 0 link blink wrong while idle");
	err_any_a : assert property (led_source_config_r[3:0] == LSS_SEL_ANY_ERR
		&& $stable(led_source_config_r) |=> indicator0_pin == $past(rx_error || tx_error))
		else $error("pin 0 not error");
	unmapped_err_a : assert property (psel && penable
		&& !hit_src && !hit_blink |-> pslverr)
		else $error("unmapped access without error");
	unmapped_wr_a : assert property (wr_en && !hit_src && !hit_blink
		|=> $stable(led_source_config_r) && $stable(indicator_blink_rate_r))
		else $error("unmapped write changed a register");

	write_cov    : cover property (wr_en && hit_src);
	blink_cov    : cover property (led_source_config_r[3:0] == LSS_SEL_LINK_BLINK && link_up
		&& tx_active ##1 !indicator0_pin);
	coll_cov     : cover property (gpio_indicator_pin && led_source_config_r[15:12] == 4'h5);
	unmapped_cov : cover property (pslverr);
	reserved_cov : cover property (led_source_config_r[3:0] == 4'hC);

endmodule : lss_top

/* tb/lss_led_board.sv */
// Board model: four discrete indicator lamps driven by the block's pins
`timescale 1ns/1ps
module lss_led_board (
	input  wire logic       pin0,
	input  wire logic       pin1,
	input  wire logic       pin2,
	input  wire logic       pin3,
	output logic      [3:0] lamp
);
	// A lamp holds no state; it shows the active high drive level only
	assign lamp = {pin3, pin2, pin1, pin0};
endmodule : lss_led_board

/* tb/tb_lss_top.sv */
// Testbench for the LED source select block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_lss_top;
	import lss_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, lamp;
	logic        link_up, full_duplex, tx_active, rx_active, collision, tx_error, rx_error;
	logic        indicator0_pin, indicator1_pin, indicator2_pin, gpio_indicator_pin;
	lss_speed_t  link_speed;
	int          n_errors, samples_checked;
	// Vector: link, speed[1:0], duplex, tx, rx, collision, tx error, rx error
	logic [8:0]  vec [4] = '{9'b1_01_1_1_0_0_0_0, 9'b1_00_0_0_1_1_0_1,
		9'b1_10_0_0_0_0_1_0, 9'b0_10_0_1_1_1_1_1};

	// Short blink half periods keep the run small: 4, 8, 16 and 32 cycles
	lss_top #(.HALF_20HZ(4), .HALF_10HZ(8), .HALF_5HZ(16), .HALF_2HZ(32)) lss_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_up(link_up), .link_speed(link_speed),
		.full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
		.collision(collision), .tx_error(tx_error), .rx_error(rx_error),
		.indicator0_pin(indicator0_pin), .indicator1_pin(indicator1_pin),
		.indicator2_pin(indicator2_pin), .gpio_indicator_pin(gpio_indicator_pin));
	lss_led_board lss_led_board_inst (.pin0(indicator0_pin), .pin1(indicator1_pin),
		.pin2(indicator2_pin), .pin3(gpio_indicator_pin), .lamp(lamp));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			n_errors++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic setv(input logic [8:0] v);
		@(posedge pclk);
		{link_up, full_duplex, tx_active, rx_active} <= {v[8], v[5:3]};
		{collision, tx_error, rx_error} <= v[2:0];
		link_speed <= lss_speed_t'(v[7:6]);
		repeat (2) @(posedge pclk);
	endtask : setv

	task automatic wait_lamp(input logic v);
		int n;
		n = 0;
		while (lamp[0] !== v && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 200) begin
			n_errors++;
			tally_and_finish();
		end
	endtask : wait_lamp

	// Blink phase is unknown in the code table, so 1011 with activity is left to t_blink
	function automatic logic exp_pin(input logic [3:0] c, input logic g, input logic [8:0] v);
		case (c)
			4'h0: return v[8];
			4'h1: return v[4] | v[3];
			4'h2: return v[4];
			4'h3: return v[3];
			4'h5: return g ? v[2] : v[8] & (v[7:6] == 2'h2);
			4'h6: return v[8] & (v[7:6] == 2'h1);
			4'h7: return v[8] & (v[7:6] == 2'h0);
			4'h8: return v[8] & (v[7:6] != 2'h2);
			4'h9: return v[8] & (v[7:6] != 2'h0);
			4'hA: return v[8] & v[5];
			4'hB: return v[8];
			4'hD: return v[1] | v[0];
			4'hE: return v[0];
			default: return 1'b0;
		endcase
	endfunction : exp_pin

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		`CHK(lamp, 4'h0)
		apb(1'b0, LSS_SRC_CFG_OFF, 32'h0000_0000);
		`CHK(rd, 32'h0000_6150)
		apb(1'b0, LSS_BLINK_CFG_OFF, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		`CHK(err, 1'b1)
		apb(1'b0, 12'h020, 32'h0000_0000);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
	endtask : t_reset

	task automatic t_codes();
		logic [3:0] c;
		for (int k = 0; k < 16; k++) begin
			c = k[3:0];
			apb(1'b1, LSS_SRC_CFG_OFF, {16'h0000, {4{c}}});
			apb(1'b0, LSS_SRC_CFG_OFF, 32'h0000_0000);
			`CHK(rd, {16'h0000, {4{c}}})
			for (int i = 0; i < 4; i++) begin
				setv(vec[i]);
				if (c != 4'hB || !(vec[i][4] | vec[i][3])) begin
					`CHK(lamp[2:0], {3{exp_pin(c, 1'b0, vec[i])}})
					`CHK(lamp[3], exp_pin(c, 1'b1, vec[i]))
				end
			end
		end
	endtask : t_codes

	task automatic t_fields();
		apb(1'b1, LSS_SRC_CFG_OFF, 32'h0000_E320);
		setv(vec[1]);
		`CHK(lamp, 4'b1101)
		setv(vec[2]);
		`CHK(lamp, 4'b0001)
		// Only lane 1 enabled: the upper selector byte changes, the lower one keeps its value
		pstrb <= 4'h2;
		apb(1'b1, LSS_SRC_CFG_OFF, 32'h0000_0F0F);
		pstrb <= 4'hF;
		apb(1'b0, LSS_SRC_CFG_OFF, 32'h0000_0000);
		`CHK(rd, 32'h0000_0F20)
	endtask : t_fields

	task automatic t_blink();
		int n;
		apb(1'b1, LSS_SRC_CFG_OFF, 32'h0000_000B);
		setv(9'b1_01_0_1_0_0_0_0);
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, LSS_BLINK_CFG_OFF, r);
			wait_lamp(1'b1);
			wait_lamp(1'b0);
			wait_lamp(1'b1);
			n = 0;
			while (lamp[0] === 1'b1 && n < 100) begin
				@(posedge pclk);
				n++;
			end
			`CHK(n, 4 << r)
		end
	endtask : t_blink

	initial begin
		n_errors = 0;
		samples_checked = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		{link_up, full_duplex, tx_active, rx_active, collision, tx_error, rx_error} = '0;
		link_speed = LSS_SPD_10;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_codes();
		t_fields();
		t_blink();
		tally_and_finish();
	end
endmodule : tb_lss_top
